// ### design/fbbu_defines.svh
/*
 * constants of the flag, bit and branch unit: bus offsets, status flag
 * positions, reset values and cycle counts.
 * assumes an 8-bit status flag register and a word-addressed program counter.
 */
`ifndef FBBU_DEFINES_SVH
`define FBBU_DEFINES_SVH

// ---------------------------------------------------------------
// status flag positions
// ---------------------------------------------------------------
`define FBBU_FLAG_C 3'h0
`define FBBU_FLAG_Z 3'h1
`define FBBU_FLAG_N 3'h2
`define FBBU_FLAG_V 3'h3
`define FBBU_FLAG_S 3'h4
`define FBBU_FLAG_H 3'h5
`define FBBU_FLAG_T 3'h6
`define FBBU_FLAG_I 3'h7

// ---------------------------------------------------------------
// bus register offsets (byte addresses, low 12 bits decoded)
// ---------------------------------------------------------------
`define FBBU_OFS_FLAGS 12'h000
`define FBBU_OFS_PC 12'h004
`define FBBU_OFS_CTRL 12'h008
`define FBBU_OFS_STATE 12'h00C

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define FBBU_FLAGS_RST 8'h00
`define FBBU_PC_RST 16'h0000
`define FBBU_CTRL_RST 1'h1
`define FBBU_CTRL_EN_BIT 0

// ---------------------------------------------------------------
// cycle counts
// ---------------------------------------------------------------
`define FBBU_CYC_SHORT 2'h1
`define FBBU_CYC_LONG 2'h2

`endif

// ### design/fbbu_pkg.sv
/*
 * types of the flag, bit and branch unit: operation codes and states.
 * assumes the instruction decoder drives one of these codes per request.
 */
package fbbu_pkg;

   // ---------------------------------------------------------------
   // operations handed over by the decoder
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE = 5'h00,
      OP_BRANCH_TRANSFER_FLAG_CLEAR = 5'h01,
      OP_BRANCH_OVERFLOW_FLAG_ONE = 5'h02,
      OP_BRANCH_OVERFLOW_FLAG_ZERO = 5'h03,
      OP_BRANCH_IRQ_ENABLED = 5'h04,
      OP_BRANCH_IRQ_DISABLED = 5'h05,
      OP_IO_BIT_FORCE_ONE = 5'h06,
      OP_IO_BIT_FORCE_ZERO = 5'h07,
      OP_LEFT_ROTATE_VIA_CARRY = 5'h08,
      OP_RIGHT_ROTATE_VIA_CARRY = 5'h09,
      OP_GENERIC_FLAG_FORCE_ONE = 5'h0A,
      OP_GENERIC_FLAG_FORCE_ZERO = 5'h0B,
      OP_REG_BIT_TO_TRANSFER_FLAG = 5'h0C,
      OP_TRANSFER_FLAG_TO_REG_BIT = 5'h0D,
      OP_CARRY_FORCE_ONE = 5'h0E,
      OP_CARRY_FORCE_ZERO = 5'h0F,
      OP_NEGATIVE_FORCE_ONE = 5'h10,
      OP_NEGATIVE_FORCE_ZERO = 5'h11,
      OP_ZERO_FLAG_FORCE_ONE = 5'h12,
      OP_ZERO_FLAG_FORCE_ZERO = 5'h13,
      OP_GLOBAL_IRQ_ON = 5'h14,
      OP_GLOBAL_IRQ_OFF = 5'h15,
      OP_SIGN_FLAG_FORCE_ONE = 5'h16,
      OP_SIGN_FLAG_FORCE_ZERO = 5'h17,
      OP_OVERFLOW_FORCE_ONE = 5'h18,
      OP_OVERFLOW_FORCE_ZERO = 5'h19
   } fbbu_op_t;

   // ---------------------------------------------------------------
   // sequencer states, gray along idle -> second
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SECOND = 2'h1
   } fbbu_state_t;

endpackage

// ### design/fbbu_top.sv
/*
 * flag, bit and branch execution unit with an ahb-lite register slave.
 * assumes one decoder request per op_valid while op_ready is high, operands
 * stable in that cycle, and io read data valid in the same cycle as io_rd_en.
 */
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "fbbu_defines.svh"

module fbbu_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // decoder request
   input wire logic op_valid,
   input wire logic [4:0] op_code,
   input wire logic [6:0] op_offset,
   input wire logic [2:0] op_bit,
   input wire logic [4:0] op_io_addr,
   input wire logic [7:0] op_reg_data,
   output logic op_ready,
   output logic op_done,
   // register file write
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   // io space
   output logic io_rd_en,
   output logic io_wr_en,
   output logic [4:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // core state
   output logic [7:0] status_flags_register,
   output logic [15:0] pc,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // branch condition of a branch op against the current flags
   function automatic logic br_cond(input fbbu_pkg::fbbu_op_t op, input logic [7:0] f);
      logic c;
      c = 1'b0;
      case (op)
         fbbu_pkg::OP_BRANCH_TRANSFER_FLAG_CLEAR: c = ~f[`FBBU_FLAG_T];
         fbbu_pkg::OP_BRANCH_OVERFLOW_FLAG_ONE: c = f[`FBBU_FLAG_V];
         fbbu_pkg::OP_BRANCH_OVERFLOW_FLAG_ZERO: c = ~f[`FBBU_FLAG_V];
         fbbu_pkg::OP_BRANCH_IRQ_ENABLED: c = f[`FBBU_FLAG_I];
         fbbu_pkg::OP_BRANCH_IRQ_DISABLED: c = ~f[`FBBU_FLAG_I];
         default: c = 1'b0;
      endcase
      return c;
   endfunction

   function automatic logic is_branch(input fbbu_pkg::fbbu_op_t op);
      return op inside {fbbu_pkg::OP_BRANCH_TRANSFER_FLAG_CLEAR,
         fbbu_pkg::OP_BRANCH_OVERFLOW_FLAG_ONE, fbbu_pkg::OP_BRANCH_OVERFLOW_FLAG_ZERO,
         fbbu_pkg::OP_BRANCH_IRQ_ENABLED, fbbu_pkg::OP_BRANCH_IRQ_DISABLED};
   endfunction

   function automatic logic is_io(input fbbu_pkg::fbbu_op_t op);
      return op inside {fbbu_pkg::OP_IO_BIT_FORCE_ONE, fbbu_pkg::OP_IO_BIT_FORCE_ZERO};
   endfunction

   // signed relative target: pc + offset + 1
   function automatic logic [15:0] br_target(input logic [15:0] p, input logic [6:0] k);
      return p + {{9{k[6]}}, k} + 16'h0001;
   endfunction

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   fbbu_pkg::fbbu_state_t state_q;
   fbbu_pkg::fbbu_op_t op_in;
   fbbu_pkg::fbbu_op_t op_q;
   logic [6:0] off_q;
   logic [2:0] bit_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic flag_upd;
   logic [15:0] pc_q;
   logic ready_q;
   logic done_q;
   logic accept;
   logic long_op;
   logic [7:0] rot_res;
   logic rot_c;
   logic ctrl_en_q;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic bus_wr;
   logic bus_flags_wr;
   logic reg_wr_en_q;
   logic [7:0] reg_wr_data_q;
   logic io_rd_en_q;
   logic io_wr_en_q;
   logic [4:0] io_addr_q;
   logic [7:0] io_wdata_q;
   logic [31:0] hrdata_q;

   assign op_in = fbbu_pkg::fbbu_op_t'(op_code);
   assign accept = op_valid && ready_q;
   // two-cycle ops: taken branches and io bit writes
   assign long_op = (is_branch(op_in) && br_cond(op_in, flags_q)) || is_io(op_in);
   assign bus_wr = wr_pend_q && hready;

   // ---------------------------------------------------------------
   // rotate and flag datapath
   // ---------------------------------------------------------------
   // single-cycle ops settle here; instruction updates win over bus writes
   always_comb
   begin
      flags_d = flags_q;
      flag_upd = 1'b0;
      rot_res = 8'h00;
      rot_c = 1'b0;
      if (op_in == fbbu_pkg::OP_LEFT_ROTATE_VIA_CARRY)
      begin
         rot_res = {op_reg_data[6:0], flags_q[`FBBU_FLAG_C]};
         rot_c = op_reg_data[7];
      end
      else
      begin
         rot_res = {flags_q[`FBBU_FLAG_C], op_reg_data[7:1]};
         rot_c = op_reg_data[0];
      end
      if (accept)
      begin
         flag_upd = 1'b1;
         case (op_in)
            fbbu_pkg::OP_LEFT_ROTATE_VIA_CARRY, fbbu_pkg::OP_RIGHT_ROTATE_VIA_CARRY:
            begin
               flags_d[`FBBU_FLAG_Z] = (rot_res == 8'h00);
               flags_d[`FBBU_FLAG_C] = rot_c;
               flags_d[`FBBU_FLAG_N] = rot_res[7];
               flags_d[`FBBU_FLAG_V] = rot_res[7] ^ rot_c;
            end
            fbbu_pkg::OP_REG_BIT_TO_TRANSFER_FLAG:
               flags_d[`FBBU_FLAG_T] = op_reg_data[op_bit];
            fbbu_pkg::OP_GENERIC_FLAG_FORCE_ONE: flags_d[op_bit] = 1'b1;
            fbbu_pkg::OP_GENERIC_FLAG_FORCE_ZERO: flags_d[op_bit] = 1'b0;
            fbbu_pkg::OP_CARRY_FORCE_ONE: flags_d[`FBBU_FLAG_C] = 1'b1;
            fbbu_pkg::OP_CARRY_FORCE_ZERO: flags_d[`FBBU_FLAG_C] = 1'b0;
            fbbu_pkg::OP_NEGATIVE_FORCE_ONE: flags_d[`FBBU_FLAG_N] = 1'b1;
            fbbu_pkg::OP_NEGATIVE_FORCE_ZERO: flags_d[`FBBU_FLAG_N] = 1'b0;
            fbbu_pkg::OP_ZERO_FLAG_FORCE_ONE: flags_d[`FBBU_FLAG_Z] = 1'b1;
            fbbu_pkg::OP_ZERO_FLAG_FORCE_ZERO: flags_d[`FBBU_FLAG_Z] = 1'b0;
            fbbu_pkg::OP_GLOBAL_IRQ_ON: flags_d[`FBBU_FLAG_I] = 1'b1;
            fbbu_pkg::OP_GLOBAL_IRQ_OFF: flags_d[`FBBU_FLAG_I] = 1'b0;
            fbbu_pkg::OP_SIGN_FLAG_FORCE_ONE: flags_d[`FBBU_FLAG_S] = 1'b1;
            fbbu_pkg::OP_SIGN_FLAG_FORCE_ZERO: flags_d[`FBBU_FLAG_S] = 1'b0;
            fbbu_pkg::OP_OVERFLOW_FORCE_ONE: flags_d[`FBBU_FLAG_V] = 1'b1;
            fbbu_pkg::OP_OVERFLOW_FORCE_ZERO: flags_d[`FBBU_FLAG_V] = 1'b0;
            default: flag_upd = 1'b0; // branches, io and bit load keep flags
         endcase
      end
   end

   assign bus_flags_wr = bus_wr && (wr_addr_q == `FBBU_OFS_FLAGS) && !flag_upd;

   // status flags: the instruction path has priority over software
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         flags_q <= `FBBU_FLAGS_RST;
      else if (flag_upd)
         flags_q <= flags_d;
      else if (bus_flags_wr)
         flags_q <= hwdata[7:0];
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // a long op holds ready low for exactly one extra cycle
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_q <= fbbu_pkg::ST_IDLE;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         op_q <= fbbu_pkg::OP_NONE;
         off_q <= 7'h00;
         bit_q <= 3'h0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            fbbu_pkg::ST_IDLE:
            begin
               ready_q <= ctrl_en_q;
               if (accept)
               begin
                  op_q <= op_in;
                  off_q <= op_offset;
                  bit_q <= op_bit;
                  if (long_op)
                  begin
                     state_q <= fbbu_pkg::ST_SECOND;
                     ready_q <= 1'b0;
                  end
                  else
                     done_q <= 1'b1;
               end
            end
            fbbu_pkg::ST_SECOND:
            begin
               state_q <= fbbu_pkg::ST_IDLE;
               ready_q <= ctrl_en_q;
               done_q <= 1'b1;
            end
            default: state_q <= fbbu_pkg::ST_IDLE;
         endcase
      end
   end

   // program counter: taken branches land in the second cycle
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pc_q <= `FBBU_PC_RST;
      else if (state_q == fbbu_pkg::ST_SECOND)
         pc_q <= is_branch(op_q) ? br_target(pc_q, off_q) : pc_q + 16'h0001;
      else if (accept && !long_op)
         pc_q <= pc_q + 16'h0001;
      else if (bus_wr && (wr_addr_q == `FBBU_OFS_PC) && state_q == fbbu_pkg::ST_IDLE)
         pc_q <= hwdata[15:0];
   end

   // ---------------------------------------------------------------
   // register file and io side effects
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         reg_wr_en_q <= 1'b0;
         reg_wr_data_q <= 8'h00;
      end
      else
      begin
         reg_wr_en_q <= 1'b0;
         if (accept && (op_in == fbbu_pkg::OP_LEFT_ROTATE_VIA_CARRY ||
            op_in == fbbu_pkg::OP_RIGHT_ROTATE_VIA_CARRY))
         begin
            reg_wr_en_q <= 1'b1;
            reg_wr_data_q <= rot_res;
         end
         else if (accept && op_in == fbbu_pkg::OP_TRANSFER_FLAG_TO_REG_BIT)
         begin
            reg_wr_en_q <= 1'b1;
            reg_wr_data_q <= op_reg_data;
            reg_wr_data_q[op_bit] <= flags_q[`FBBU_FLAG_T];
         end
      end
   end

   // io bit ops: read in the first cycle, modified write in the second
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         io_rd_en_q <= 1'b0;
         io_wr_en_q <= 1'b0;
         io_addr_q <= 5'h00;
         io_wdata_q <= 8'h00;
      end
      else
      begin
         io_rd_en_q <= 1'b0;
         io_wr_en_q <= 1'b0;
         if (accept && is_io(op_in))
         begin
            io_rd_en_q <= 1'b1;
            io_addr_q <= op_io_addr;
         end
         else if (state_q == fbbu_pkg::ST_SECOND && is_io(op_q))
         begin
            io_wr_en_q <= 1'b1;
            io_wdata_q <= io_rdata;
            io_wdata_q[bit_q] <= (op_q == fbbu_pkg::OP_IO_BIT_FORCE_ONE);
         end
      end
   end

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------------
   // read data is fetched in the address phase so hrdata comes from a flop
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         hrdata_q <= 32'h00000000;
         ctrl_en_q <= `FBBU_CTRL_RST;
      end
      else
      begin
         if (bus_wr && wr_addr_q == `FBBU_OFS_CTRL)
            ctrl_en_q <= hwdata[`FBBU_CTRL_EN_BIT];
         if (hready)
         begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr[11:0];
            hrdata_q <= 32'h00000000;
            if (hsel && htrans[1] && !hwrite)
            begin
               if (haddr[11:0] == `FBBU_OFS_FLAGS)
                  hrdata_q <= {24'h000000, flags_q};
               else if (haddr[11:0] == `FBBU_OFS_PC)
                  hrdata_q <= {16'h0000, pc_q};
               else if (haddr[11:0] == `FBBU_OFS_CTRL)
                  hrdata_q <= {31'h00000000, ctrl_en_q};
               else if (haddr[11:0] == `FBBU_OFS_STATE)
                  hrdata_q <= {24'h000000, op_q, 1'b0, state_q};
            end
         end
      end
   end

   assign hreadyout = 1'b1; // constant: never stalls
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign op_ready = ready_q;
   assign op_done = done_q;
   assign reg_wr_en = reg_wr_en_q;
   assign reg_wr_data = reg_wr_data_q;
   assign io_rd_en = io_rd_en_q;
   assign io_wr_en = io_wr_en_q;
   assign io_addr = io_addr_q;
   assign io_wdata = io_wdata_q;
   assign status_flags_register = flags_q;
   assign pc = pc_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   tclr_branch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_BRANCH_TRANSFER_FLAG_CLEAR && !flags_q[`FBBU_FLAG_T]
      |=> !done_q ##1 done_q && pc_q == br_target($past(pc_q, 2), $past(op_offset, 2)))
      else $error("transfer-clear branch target or timing wrong");

   ovf_branch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_BRANCH_OVERFLOW_FLAG_ONE && !flags_q[`FBBU_FLAG_V]
      && !bus_wr |=> done_q && pc_q == $past(pc_q) + 16'h0001 && $stable(flags_q))
      else $error("overflow branch not-taken path wrong");

   irq_branch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_BRANCH_IRQ_ENABLED && flags_q[`FBBU_FLAG_I]
      |=> state_q == fbbu_pkg::ST_SECOND ##1 done_q)
      else $error("interrupt branch did not take two cycles");

   io_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_IO_BIT_FORCE_ONE |=> io_rd_en_q
      ##1 io_wr_en_q && io_wdata_q[$past(op_bit, 2)] && done_q)
      else $error("io bit force one wrong");

   io_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_IO_BIT_FORCE_ZERO && !bus_wr ##1 !bus_wr
      |=> io_wr_en_q && !io_wdata_q[$past(op_bit, 2)] && $stable(flags_q))
      else $error("io bit force zero wrong");

   rot_left_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_LEFT_ROTATE_VIA_CARRY |=> reg_wr_en_q
      && reg_wr_data_q == {$past(op_reg_data[6:0]), $past(flags_q[`FBBU_FLAG_C])}
      && flags_q[`FBBU_FLAG_C] == $past(op_reg_data[7]))
      else $error("left rotate result wrong");

   rot_right_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_RIGHT_ROTATE_VIA_CARRY |=>
      reg_wr_data_q == {$past(flags_q[`FBBU_FLAG_C]), $past(op_reg_data[7:1])}
      && flags_q[`FBBU_FLAG_C] == $past(op_reg_data[0])
      && flags_q[`FBBU_FLAG_V] == (flags_q[`FBBU_FLAG_N] ^ flags_q[`FBBU_FLAG_C]))
      else $error("right rotate result wrong");

   bit_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_REG_BIT_TO_TRANSFER_FLAG |=>
      flags_q[`FBBU_FLAG_T] == $past(op_reg_data[op_bit])
      && flags_q[5:0] == $past(flags_q[5:0]) && !reg_wr_en_q)
      else $error("bit store wrong");

   bit_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_TRANSFER_FLAG_TO_REG_BIT && !bus_wr |=>
      reg_wr_en_q && reg_wr_data_q[$past(op_bit)] == flags_q[`FBBU_FLAG_T] && $stable(flags_q))
      else $error("bit load wrong");

   sign_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_SIGN_FLAG_FORCE_ONE |=> flags_q[`FBBU_FLAG_S]
      && (flags_q ^ $past(flags_q)) inside {8'h00, 8'h10} && done_q)
      else $error("sign force touched other flags");

   ovf_force_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_OVERFLOW_FORCE_ZERO |=> !flags_q[`FBBU_FLAG_V]
      && (flags_q ^ $past(flags_q)) inside {8'h00, 8'h08})
      else $error("overflow force touched other flags");

   generic_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
      accept && op_in == fbbu_pkg::OP_GENERIC_FLAG_FORCE_ZERO |=>
      flags_q == ($past(flags_q) & ~(8'h01 << $past(op_bit))) && done_q)
      else $error("generic flag clear wrong");

endmodule

// ### sim/flag_bit_branch_unit_bench.sv
/*
 * self-checking bench of the flag, bit and branch unit: decoder ops and
 * ahb-lite register accesses driven as task sequences with worked-out results.
 * assumes the single slave answers on hreadyout and io_rdata may stay constant.
 */
`timescale 1ns/1ps

module flag_bit_branch_unit_bench;
   // clock and reset
   logic mclk;
   logic rst_n;
   // decoder side
   logic op_valid, op_ready, op_done, reg_wr_en, io_rd_en, io_wr_en;
   logic [4:0] op_code, op_io_addr, io_addr;
   logic [6:0] op_offset;
   logic [2:0] op_bit;
   logic [7:0] op_reg_data, reg_wr_data, io_wdata, io_rdata, status_flags_register;
   logic [15:0] pc;
   // register bus
   logic hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   // expectations and captures
   logic [7:0] exp_f, rw;
   logic [15:0] exp_pc;
   logic [4:0] rd_a;
   logic [12:0] wr_d;
   int miscompares = 0, tests_run = 0, cycles = 0;
   int fl[6] = '{0, 2, 1, 7, 4, 3}; // flag bit of each force pair, in code order
   logic bc[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0}; // flag level that makes each branch jump

   assign hready = hreadyout; // one slave, so its ready is the bus ready
   fbbu_top dut (.mclk, .rst_n, .op_valid, .op_code, .op_offset, .op_bit, .op_io_addr,
      .op_reg_data, .op_ready, .op_done, .reg_wr_en, .reg_wr_data, .io_rd_en, .io_wr_en,
      .io_addr, .io_wdata, .io_rdata, .status_flags_register, .pc, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);

   // ---------------------------------------------------------------
   // clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // a hung handshake ends the run here instead of spinning forever
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles >= 3000)
      begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   // single word transfer; data read is taken at the edge closing the data phase
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      r = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
   endtask

   // one decoder op; pc expectation follows from the taken flag and the offset
   task automatic op(input logic [4:0] c, input logic [6:0] k, input logic [2:0] b,
      input logic [4:0] ia, input logic [7:0] rd, input logic tk, input int ecyc);
      int n;
      op_valid <= 1'b1;
      op_code <= c;
      op_offset <= k;
      op_bit <= b;
      op_io_addr <= ia;
      op_reg_data <= rd;
      rw = 'x;
      rd_a = 'x;
      wr_d = 'x;
      @(posedge mclk);
      while (op_ready !== 1'b1) @(posedge mclk);
      op_valid <= 1'b0;
      exp_pc = tk ? exp_pc + {{9{k[6]}}, k} + 16'h1 : exp_pc + 16'h1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
         if (io_rd_en === 1'b1) rd_a = io_addr;
         if (io_wr_en === 1'b1) wr_d = {io_addr, io_wdata};
         if (reg_wr_en === 1'b1) rw = reg_wr_data;
      end
      while (op_done !== 1'b1 && n < 4);
      chk("cycles", 32'(n), 32'(ecyc));
      chk("flags", 32'(status_flags_register), 32'(exp_f));
      chk("pc", 32'(pc), 32'(exp_pc));
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {op_valid, op_code, op_offset, op_bit, op_io_addr, op_reg_data} = '0;
      {hwrite, htrans, haddr, hwdata} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      io_rdata = 8'hA5;
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      chk("flags_rst", 32'(status_flags_register), 32'h0);
      chk("pc_rst", 32'(pc), 32'h0);
      exp_pc = 16'h0;
      ahb(1'b0, 32'h10, 32'h0);
      chk("unmapped", r, 32'h0);
      ahb(1'b1, 32'h0, 32'h5A);
      exp_f = 8'h5A;
      // every dedicated force pair, then the generic pair over all eight bits
      for (int i = 0; i < 12; i++)
      begin
         exp_f[fl[i / 2]] = ~i[0];
         op(5'h0E + 5'(i), 7'h0, 3'h0, 5'h0, 8'h0, 1'b0, 1);
      end
      for (int i = 0; i < 16; i++)
      begin
         exp_f[i / 2] = ~i[0];
         op(5'h0A + 5'(i % 2), 7'h0, 3'(i / 2), 5'h0, 8'h0, 1'b0, 1);
      end
      // each branch taken and not, at both offset extremes
      for (int i = 0; i < 20; i++)
      begin
         exp_f = {8{i[0] ~^ bc[i / 4]}};
         ahb(1'b1, 32'h0, {24'h0, exp_f});
         ahb(1'b1, 32'h4, 32'h0100);
         exp_pc = 16'h0100;
         op(5'h01 + 5'(i / 4), i[1] ? 7'h40 : 7'h3F, 3'h0, 5'h0, 8'h0, i[0],
            i[0] ? 2 : 1);
      end
      ahb(1'b1, 32'h0, 32'h01);
      exp_f = 8'h09;
      op(5'h08, 7'h0, 3'h0, 5'h0, 8'h81, 1'b0, 1);
      chk("rotl", 32'(rw), 32'h03);
      ahb(1'b1, 32'h0, 32'h70);
      exp_f = 8'h7B;
      op(5'h09, 7'h0, 3'h0, 5'h0, 8'h01, 1'b0, 1);
      chk("rotr", 32'(rw), 32'h00);
      ahb(1'b1, 32'h0, 32'h0);
      exp_f = 8'h40;
      op(5'h0C, 7'h0, 3'h5, 5'h0, 8'h20, 1'b0, 1);
      op(5'h0D, 7'h0, 3'h3, 5'h0, 8'h00, 1'b0, 1);
      chk("bitload", 32'(rw), 32'h08);
      op(5'h06, 7'h0, 3'h1, 5'h1F, 8'h0, 1'b0, 2);
      chk("io_rd", 32'(rd_a), 32'h1F);
      chk("io_set", 32'(wr_d), {19'h0, 5'h1F, 8'hA7});
      op(5'h07, 7'h0, 3'h0, 5'h00, 8'h0, 1'b0, 2);
      chk("io_clr", 32'(wr_d), {19'h0, 5'h00, 8'hA4});
      // status word holds the last op code and the idle state
      ahb(1'b0, 32'hC, 32'h0);
      chk("state_rd", r, 32'h38);
      // a cleared enable must hold off the decoder, ready takes one more edge to fall
      ahb(1'b1, 32'h8, 32'h0);
      repeat (2) @(posedge mclk);
      chk("ready_off", 32'(op_ready), 32'h0);
      ahb(1'b0, 32'h8, 32'h0);
      chk("ctrl_rd", r, 32'h0);
      ahb(1'b1, 32'h8, 32'h1);
      repeat (2) @(posedge mclk);
      chk("ready_on", 32'(op_ready), 32'h1);
      ahb(1'b0, 32'h0, 32'h0);
      chk("flags_rd", r, 32'h40);
      test_done();
   end
endmodule
